// ===== core/ccp_cfg.svh
/*
  register offsets, field positions, reset values and mode codes of the
  capture/compare/pwm unit.
  assumes: included by bare name from the core module, the checker and the bench.
*/
`ifndef CCP_CFG_SVH
`define CCP_CFG_SVH

// byte offsets on the register bus
`define CCP_OFF_CTRL1   12'h000
`define CCP_OFF_CTRL2   12'h004
`define CCP_OFF_VAL1    12'h008
`define CCP_OFF_VAL2    12'h00C
`define CCP_OFF_TSRC    12'h010
`define CCP_OFF_STAT    12'h014
`define CCP_OFF_MASK    12'h018

// control field positions
`define CCP_MODE_LSB    0
`define CCP_MODE_MSB    3
`define CCP_DUTY_LSB    4
`define CCP_DUTY_MSB    5

// reset values
`define CCP_CTRL_RST    6'h00
`define CCP_VAL_RST     16'h0000

// mode codes
`define CCP_M_OFF       4'h0
`define CCP_M_RSVD      4'h1
`define CCP_M_TOGGLE    4'h2
`define CCP_M_MSGCAP    4'h3
`define CCP_M_CAPFALL   4'h4
`define CCP_M_CAPRISE   4'h5
`define CCP_M_CAP4      4'h6
`define CCP_M_CAP16     4'h7
`define CCP_M_SETHI     4'h8
`define CCP_M_SETLO     4'h9
`define CCP_M_SWINT     4'hA
`define CCP_M_SPECIAL   4'hB

// edge prescale terminal counts
`define CCP_PRE4_LAST   4'h3
`define CCP_PRE16_LAST  4'hF

`endif

// ===== core/ccp_pkg.sv
/*
  types shared by the capture/compare/pwm unit.
  assumes: nothing beyond the config header.
*/
package ccp_pkg;
  // operating class decoded from the mode field
  typedef enum logic [3:0] {
    CCP_CLS_OFF  = 4'b0001,
    CCP_CLS_CAP  = 4'b0010,
    CCP_CLS_CMP  = 4'b0100,
    CCP_CLS_PWM  = 4'b1000
  } ccp_class_e;
endpackage

// ===== core/ccp_unit.sv
/*
  capture/compare/pwm block: two units, each with a 16-bit value register
  and a 6-bit control register, reached over axi4-lite.
  assumes: timer values come from logic on clk; capture pins and the
  message-received strobe are asynchronous and synchronised here.
*/
`timescale 1ns/100ps
`include "ccp_cfg.svh"

//------------------------------------------------------------------
// Function
// [R01] each unit has one 16-bit register
// [R02] unit two lacks message capture, special event
// [R03] mode in bits 3..0; 0001 reserved
// [R04] mode 0000 off, resets unit state
// [R05] 0010 compare toggles pin, sets flag
// [R06] 0011 captures on message received, unit one
// [R07] 0100..0111 capture falling/rising/4th/16th edge
// [R08] 1000 pin low, match forces high
// [R09] 1001 pin high, match forces low
// [R10] 1010 match sets flag only
// [R11] 1011 match sets flag, resets timer
// [R12] 11xx pwm, 10-bit duty split
// [R13] bits 7..6 read zero; reset zero
// [R14] two-bit timer source select field
// [R15] capture copies timer, sets flag
// [R16] compare match is timer equals register
// [R17] duty bits ignored outside pwm
//------------------------------------------------------------------

module ccp_unit #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [15:0]       firstTimer,
  input  wire logic [15:0]       thirdTimer,
  input  wire logic [1:0]        capPin,
  input  wire logic              msgReceived,
  output logic [1:0]             cmpPin,
  output logic                   firstTimerReset,
  output logic                   thirdTimerReset,
  output logic                   irq
);

  // elaboration check: the register map needs five address bits
  if (ADDR_W < 5) begin : gAddrCheck
    $error("ADDR_W too small for register map");
  end

  //------------------------------------------------------------------
  // mode decoding
  //------------------------------------------------------------------
  // class of a mode code; the reserved code 0001 decodes as off
  function automatic ccp_pkg::ccp_class_e modeClass(input logic [3:0] m);
    ccp_pkg::ccp_class_e c;
    c = ccp_pkg::CCP_CLS_OFF;
    if (m[3:2] == 2'b11) c = ccp_pkg::CCP_CLS_PWM;
    else if (m[3:2] == 2'b01 || m == `CCP_M_MSGCAP) c = ccp_pkg::CCP_CLS_CAP;
    else if (m[3] || m == `CCP_M_TOGGLE) c = ccp_pkg::CCP_CLS_CMP;
    return c;
  endfunction

  //------------------------------------------------------------------
  // registers
  //------------------------------------------------------------------
  logic [5:0]  ctrl_reg [2];     // duty low bits and mode per unit
  logic [15:0] val_reg  [2];     // capture/compare/duty register
  logic [1:0]  tsrc_reg;         // timer source select
  logic [1:0]  stat_reg;         // sticky unit interrupt flags
  logic [1:0]  mask_reg;         // interrupt enables
  logic [1:0]  pin_reg;          // compare output pins
  logic [2:0]  capSync_reg [2];  // three-stage pin synchronisers
  logic [2:0]  msgSync_reg;      // message strobe synchroniser
  logic [3:0]  preCnt_reg  [2];  // edge prescale counters
  logic [9:0]  pwmCnt_reg  [2];  // pwm period counters
  logic [3:0]  modePrev_reg [2]; // mode seen in the last cycle
  logic        special_reg;      // special event pulse
  logic        awPend_reg;       // write address taken
  logic        wPend_reg;        // write data taken
  logic [ADDR_W-1:0] awAddr_reg; // held write address
  logic [31:0] wData_reg;        // held write data
  logic [3:0]  wStrb_reg;        // held byte strobes

  //------------------------------------------------------------------
  // axi4-lite write channel
  //------------------------------------------------------------------
  // a write fires once both halves are held and no answer is pending;
  // a master that offers one half only leaves it parked here
  wire wrFire = awPend_reg && wPend_reg && !s_axi_bvalid;
  assign s_axi_awready = !awPend_reg && !s_axi_bvalid;
  assign s_axi_wready  = !wPend_reg && !s_axi_bvalid;
  assign s_axi_bresp   = 2'h0;

  // write decode uses the held address
  wire [ADDR_W-1:0] wA = awAddr_reg;
  wire selC1 = wA == ADDR_W'(`CCP_OFF_CTRL1);
  wire selC2 = wA == ADDR_W'(`CCP_OFF_CTRL2);
  wire selV1 = wA == ADDR_W'(`CCP_OFF_VAL1);
  wire selV2 = wA == ADDR_W'(`CCP_OFF_VAL2);
  wire selTs = wA == ADDR_W'(`CCP_OFF_TSRC);
  wire selSt = wA == ADDR_W'(`CCP_OFF_STAT);
  wire selMk = wA == ADDR_W'(`CCP_OFF_MASK);
  // strobe 0 writes the narrow registers, strobe 1 the value high byte
  wire wrLo  = wrFire && wStrb_reg[0];
  wire wrHi  = wrFire && wStrb_reg[1];

  // address and data captured in either order, then one response
  always_ff @(posedge clk) begin
    if (rst) begin
      awPend_reg   <= 1'b0;
      wPend_reg    <= 1'b0;
      awAddr_reg   <= '0;
      wData_reg    <= 32'h0000_0000;
      wStrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awPend_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wPend_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (wrFire) begin
        awPend_reg   <= 1'b0;
        wPend_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  //------------------------------------------------------------------
  // axi4-lite read channel
  //------------------------------------------------------------------
  // the address is decoded as it arrives, so rdata shows the
  // register contents at the accepting edge
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp   = 2'h0;
  wire [ADDR_W-1:0] rA = s_axi_araddr;
  wire [31:0] rdMux =
    // [R13] upper control bits zero
    (rA == ADDR_W'(`CCP_OFF_CTRL1)) ? {26'h0, ctrl_reg[0]} :
    (rA == ADDR_W'(`CCP_OFF_CTRL2)) ? {26'h0, ctrl_reg[1]} :
    (rA == ADDR_W'(`CCP_OFF_VAL1))  ? {16'h0, val_reg[0]} :
    (rA == ADDR_W'(`CCP_OFF_VAL2))  ? {16'h0, val_reg[1]} :
    (rA == ADDR_W'(`CCP_OFF_TSRC))  ? {30'h0, tsrc_reg} :
    (rA == ADDR_W'(`CCP_OFF_STAT))  ? {28'h0, pin_reg, stat_reg} :
    (rA == ADDR_W'(`CCP_OFF_MASK))  ? {30'h0, mask_reg} : 32'h0000_0000;

  // read data registered, held until taken
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdMux;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  //------------------------------------------------------------------
  // synchronisers for pins and message strobe
  //------------------------------------------------------------------
  // pins idle low and the stages reset low, so no edge follows reset;
  // only the shift itself reads the first stage
  always_ff @(posedge clk) begin
    if (rst) begin
      capSync_reg[0] <= 3'h0;
      capSync_reg[1] <= 3'h0;
      msgSync_reg    <= 3'h0;
    end else begin
      capSync_reg[0] <= {capSync_reg[0][1:0], capPin[0]};
      capSync_reg[1] <= {capSync_reg[1][1:0], capPin[1]};
      msgSync_reg    <= {msgSync_reg[1:0], msgReceived};
    end
  end

  // msg rising edge: third stage low, second high
  wire msgEvt = msgSync_reg[1] && !msgSync_reg[2];

  //------------------------------------------------------------------
  // timer selection
  //------------------------------------------------------------------
  // bit 1 moves both units to the third timer, code 01 only unit two
  // [R14] timer source routing
  wire [15:0] timerSel [2];
  assign timerSel[0] = tsrc_reg[1] ? thirdTimer : firstTimer;
  assign timerSel[1] = (tsrc_reg != 2'b00) ? thirdTimer : firstTimer;
  wire [1:0] useThird = {tsrc_reg != 2'b00, tsrc_reg[1]};

  //------------------------------------------------------------------
  // per-unit event logic
  //------------------------------------------------------------------
  logic [1:0] evt;         // capture or match event
  logic [1:0] capEvt;      // capture event
  logic [1:0] cmpEvt;      // compare match
  logic [1:0] pinNext;     // next output pin value
  logic [1:0] rise;        // synced rising edge
  logic [1:0] fall;        // synced falling edge
  logic [1:0] preHit;      // prescaled edge reached

  // one copy of the event and pin logic per unit
  genvar u;
  generate
    for (u = 0; u < 2; u++) begin : gUnit
      wire [3:0] mode = ctrl_reg[u][`CCP_MODE_MSB:`CCP_MODE_LSB];
      ccp_pkg::ccp_class_e cls;
      assign cls = modeClass(mode);
      wire isCap = cls == ccp_pkg::CCP_CLS_CAP;
      wire isCmp = cls == ccp_pkg::CCP_CLS_CMP;
      wire isPwm = cls == ccp_pkg::CCP_CLS_PWM;
      // the cycle after a control write the new mode is in force: the
      // set-high and set-low modes start their pin from here
      wire newMode = mode != modePrev_reg[u];
      // edges seen between the second and third stages
      assign rise[u] = capSync_reg[u][1] && !capSync_reg[u][2];
      assign fall[u] = !capSync_reg[u][1] && capSync_reg[u][2];
      // [R07] prescale terminal count
      assign preHit[u] = (mode == `CCP_M_CAP4 && preCnt_reg[u] == `CCP_PRE4_LAST) ||
                         (mode == `CCP_M_CAP16 && preCnt_reg[u] == `CCP_PRE16_LAST);
      // [R07] edge selection
      wire edgeCap = (mode == `CCP_M_CAPFALL && fall[u]) ||
                     (mode == `CCP_M_CAPRISE && rise[u]) ||
                     (rise[u] && preHit[u]);
      // [R06] [R02] message capture on unit one only
      wire msgCap = (u == 0) && mode == `CCP_M_MSGCAP && msgEvt;
      // [R15] capture event
      assign capEvt[u] = isCap && (edgeCap || msgCap);
      // [R16] compare match
      assign cmpEvt[u] = isCmp && timerSel[u] == val_reg[u] &&
                         (u == 0 || mode != `CCP_M_SPECIAL);
      // either kind of event raises the unit's flag
      assign evt[u] = capEvt[u] || cmpEvt[u];

      // [R12] pwm duty, [R17] duty bits only used here
      wire [9:0] duty = {val_reg[u][7:0], ctrl_reg[u][`CCP_DUTY_MSB:`CCP_DUTY_LSB]};

      // next pin level; a forced pin keeps its level until the mode changes
      always_comb begin
        pinNext[u] = pin_reg[u];
        // [R04] off clears pin
        if (cls == ccp_pkg::CCP_CLS_OFF) pinNext[u] = 1'b0;
        // [R05] toggle on match
        else if (mode == `CCP_M_TOGGLE && cmpEvt[u]) pinNext[u] = !pin_reg[u];
        // [R08] initialise low on selection, force high on match
        else if (mode == `CCP_M_SETHI) pinNext[u] = cmpEvt[u] || (!newMode && pin_reg[u]);
        // [R09] initialise high on selection, force low on match
        else if (mode == `CCP_M_SETLO) pinNext[u] = !cmpEvt[u] && (newMode || pin_reg[u]);
        // [R12] pwm: high while count below duty
        else if (isPwm) pinNext[u] = pwmCnt_reg[u] < duty;
        // [R10] software-interrupt mode leaves pin alone
      end

      // pin, prescaler, pwm counter and last mode
      always_ff @(posedge clk) begin
        if (rst) begin
          preCnt_reg[u]   <= 4'h0;
          pwmCnt_reg[u]   <= 10'h000;
          pin_reg[u]      <= 1'b0;
          modePrev_reg[u] <= `CCP_M_OFF;
        end else begin
          pin_reg[u]      <= pinNext[u];
          modePrev_reg[u] <= mode;
          // [R04] prescaler cleared outside capture
          // a change between capture kinds keeps the count, so software
          // passes through off to restart the prescaler
          if (!isCap) preCnt_reg[u] <= 4'h0;
          else if (rise[u]) preCnt_reg[u] <= preHit[u] ? 4'h0 : preCnt_reg[u] + 4'h1;
          // [R12] free-running period counter, wraps after 1024 clocks
          pwmCnt_reg[u] <= isPwm ? pwmCnt_reg[u] + 10'h001 : 10'h000;
        end
      end
    end
  endgenerate

  //------------------------------------------------------------------
  // control, value, status and mask registers
  //------------------------------------------------------------------
  // software writes land the cycle after the write fires
  always_ff @(posedge clk) begin
    if (rst) begin
      // [R13] reset to zero
      ctrl_reg[0] <= `CCP_CTRL_RST;
      ctrl_reg[1] <= `CCP_CTRL_RST;
      val_reg[0]  <= `CCP_VAL_RST;
      val_reg[1]  <= `CCP_VAL_RST;
      tsrc_reg    <= 2'h0;
      stat_reg    <= 2'h0;
      mask_reg    <= 2'h0;
      special_reg <= 1'b0;
    end else begin
      // [R03] mode field stored in bits 3..0
      if (wrLo && selC1) ctrl_reg[0] <= wData_reg[5:0];
      if (wrLo && selC2) ctrl_reg[1] <= wData_reg[5:0];
      if (wrLo && selTs) tsrc_reg <= wData_reg[1:0];
      if (wrLo && selMk) mask_reg <= wData_reg[1:0];
      // [R01] value register byte writes
      if (wrLo && selV1) val_reg[0][7:0]  <= wData_reg[7:0];
      if (wrHi && selV1) val_reg[0][15:8] <= wData_reg[15:8];
      if (wrLo && selV2) val_reg[1][7:0]  <= wData_reg[7:0];
      if (wrHi && selV2) val_reg[1][15:8] <= wData_reg[15:8];
      // [R15] capture overrides software write
      if (capEvt[0]) val_reg[0] <= timerSel[0];
      if (capEvt[1]) val_reg[1] <= timerSel[1];
      // flags: write one clears, event set wins
      stat_reg <= (stat_reg & ~((wrLo && selSt) ? wData_reg[1:0] : 2'h0)) | evt;
      // [R11] special event from unit one only; a timer parked on the
      // match value repeats the pulse until the timer is cleared
      special_reg <= cmpEvt[0] && ctrl_reg[0][3:0] == `CCP_M_SPECIAL;
    end
  end

  //------------------------------------------------------------------
  // outputs
  //------------------------------------------------------------------
  assign cmpPin          = pin_reg;
  // [R11] reset the timer that unit one compares against
  assign firstTimerReset = special_reg && !useThird[0];
  assign thirdTimerReset = special_reg && useThird[0];
  // level: falls only when the flag is cleared or masked
  assign irq             = |(stat_reg & mask_reg);

endmodule

// ===== tb/ccp_unit_checker.sv
/*
  port assertions of the capture/compare/pwm block.
  assumes: one clock, synchronous active-high reset, bound to ccp_unit.
*/
`timescale 1ns/100ps
`include "ccp_cfg.svh"

module ccp_unit_checker #(
  parameter int ADDR_W = 12
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [1:0]        cmpPin,
  input wire logic              firstTimerReset,
  input wire logic              thirdTimerReset,
  input wire logic              irq
);
  //----------------------------------------------------------------
  // read address tracking
  //----------------------------------------------------------------
  logic [ADDR_W-1:0] rdAddr_reg;  // address of the read under way
  wire isCtrl = rdAddr_reg == `CCP_OFF_CTRL1 || rdAddr_reg == `CCP_OFF_CTRL2;
  wire isVal  = rdAddr_reg == `CCP_OFF_VAL1 || rdAddr_reg == `CCP_OFF_VAL2;

  // capture the address of each accepted read
  always_ff @(posedge clk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rdAddr_reg <= s_axi_araddr;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  //----------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer not held");
  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
  AST_RST_OUT: assert property (disable iff (1'b0) rst |=>
    cmpPin == 2'b00 && !irq && !firstTimerReset) else $error("outputs not cleared");
  AST_EVT_PULSE: assert property (firstTimerReset |=> !firstTimerReset)
    else $error("special event longer than one cycle");
  AST_EVT_ONE: assert property (!(firstTimerReset && thirdTimerReset))
    else $error("both timer resets at once");
  AST_CTRL_RD: assert property (s_axi_rvalid && isCtrl |-> s_axi_rdata[31:6] == 26'h0)
    else $error("control upper bits not zero");
  AST_VAL_RD: assert property (s_axi_rvalid && isVal |-> s_axi_rdata[31:16] == 16'h0)
    else $error("value wider than 16 bits");
  AST_TSRC_RD: assert property (s_axi_rvalid && rdAddr_reg == `CCP_OFF_TSRC
    |-> s_axi_rdata[31:2] == 30'h0) else $error("source select wider than 2 bits");
  AST_FREE_RD: assert property (s_axi_rvalid && rdAddr_reg > `CCP_OFF_MASK
    |-> s_axi_rdata == 32'h0) else $error("unmapped read not zero");
endmodule

bind ccp_unit ccp_unit_checker #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .cmpPin(cmpPin), .firstTimerReset(firstTimerReset),
  .thirdTimerReset(thirdTimerReset), .irq(irq));

// ===== tb/ccp_timer_model.sv
/*
  the two timer counters feeding the capture/compare/pwm block.
  assumes: the bench controls count enable and preset; same clock.
*/
`timescale 1ns/100ps

module ccp_timer_model (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        run,      // count enable
  input wire logic        load,     // preset both counters
  input wire logic [15:0] loadVal,  // preset of the first counter
  input wire logic        firstTimerReset,
  input wire logic        thirdTimerReset,
  output logic     [15:0] firstTimer,
  output logic     [15:0] thirdTimer
);
  // preset, special-event clear, then count
  always_ff @(posedge clk) begin
    if (rst || load) begin
      firstTimer <= rst ? 16'h0000 : loadVal;
      thirdTimer <= rst ? 16'h0000 : loadVal ^ 16'h8000;
    end else begin
      firstTimer <= firstTimerReset ? 16'h0000 : firstTimer + {15'h0000, run};
      thirdTimer <= thirdTimerReset ? 16'h0000 : thirdTimer + {15'h0000, run};
    end
  end
endmodule

// ===== tb/ccp_unit_tb.sv
/*
  self-checking bench of the capture/compare/pwm block.
  assumes: design, timer model and checker compiled before it.
*/
`timescale 1ns/100ps
`include "ccp_cfg.svh"

module ccp_unit_tb;
  logic        clk = 1'b0, rst = 1'b1, run = 1'b0, load = 1'b0, msgReceived = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, cnt;
  logic [15:0] loadVal = 16'h0000, firstTimer, thirdTimer, base;
  logic [1:0]  capPin = 2'b00, cmpPin, bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, irq, tr1, tr3;
  logic [63:0] q[$];  // expected read words with their masks
  logic [63:0] p;
  logic [27:0] e;
  int          n_errors = 0, checked = 0, np, dv, nT1 = 0, nT3 = 0, t1, t3;
  // mode, source, preset, mask, pin at select, pin after match, flag
  logic [27:0] TBL [10] = '{28'h200000B, 28'h800000B, 28'h900000D, 28'hA000009,
                            28'hB000009, 28'hA280009, 28'hA080008, 28'hA000001,
                            28'hB280009, 28'hA180008};

  always #50 clk = ~clk;

  ccp_unit u_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .firstTimer(firstTimer), .thirdTimer(thirdTimer), .capPin(capPin),
    .msgReceived(msgReceived), .cmpPin(cmpPin), .firstTimerReset(tr1),
    .thirdTimerReset(tr3), .irq(irq));
  ccp_timer_model u_tmr (.clk(clk), .rst(rst), .run(run), .load(load), .loadVal(loadVal),
    .firstTimerReset(tr1), .thirdTimerReset(tr3), .firstTimer(firstTimer),
    .thirdTimer(thirdTimer));

  //----------------------------------------------------------------
  // tasks
  //----------------------------------------------------------------
  task automatic cmp32(input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      n_errors++;
      $display("mismatch at %0t: expected %h got %h", $time, x, g);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // write one word; address and data released as each is taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ha, hw, da, dw;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    da = 1'b0; dw = 1'b0;
    while (!(da && dw)) begin
      @(negedge clk);
      ha = awvalid && awready === 1'b1; hw = wvalid && wready === 1'b1;
      @(posedge clk);
      if (ha) begin awvalid <= 1'b0; da = 1'b1; end
      if (hw) begin wvalid <= 1'b0; dw = 1'b1; end
    end
    bready <= 1'b1;
    do @(negedge clk); while (bvalid !== 1'b1);
    @(posedge clk);
    bready <= 1'b0;
  endtask

  // read one word; the expectation goes to the queue first
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m = '1);
    q.push_back({m, x});
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0; rready <= 1'b1;
    do @(negedge clk); while (rvalid !== 1'b1);
    @(posedge clk);
    rready <= 1'b0;
  endtask

  // preset the held counters
  task automatic setT(input logic [15:0] v);
    @(posedge clk); load <= 1'b1; loadVal <= v;
    @(posedge clk); load <= 1'b0;
  endtask

  // one pin pulse: counter v at the rise, ~v at the fall
  task automatic pulse(input logic [15:0] v);
    setT(v); capPin[0] <= 1'b1; repeat (6) @(posedge clk);
    setT(~v); capPin[0] <= 1'b0; repeat (6) @(posedge clk);
  endtask

  // take the oldest note at each read answer
  always @(negedge clk) begin
    if (rvalid === 1'b1 && rready) begin
      p = q.pop_front();
      cmp32(p[31:0], rdata & p[63:32]);
    end
  end

  // count special-event pulses seen at the timers
  always @(negedge clk) begin
    if (tr1 === 1'b1) nT1++;
    if (tr3 === 1'b1) nT3++;
  end

  // hang guard
  initial begin
    #2_000_000;
    n_errors++;
    results();
  end

  //----------------------------------------------------------------
  // tests
  //----------------------------------------------------------------
  initial begin
    void'($urandom(62268));
    base = 16'($urandom());
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 32; a += 4) rd(12'(a), 32'h0);
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      e = TBL[i];
      wr(`CCP_OFF_MASK, {31'h0, e[3]});
      wr(`CCP_OFF_TSRC, {28'h0, e[23:20]});
      wr(`CCP_OFF_VAL1, 32'h10);
      setT(e[19:4]);
      wr(`CCP_OFF_CTRL1, {28'h0, e[27:24]});
      t1 = nT1;
      t3 = nT3;
      @(negedge clk) cmp32({31'h0, e[2]}, {30'h0, cmpPin});
      @(posedge clk) run <= 1'b1;
      repeat (40) @(posedge clk);
      run <= 1'b0;
      @(negedge clk) cmp32({31'h0, e[1]}, {30'h0, cmpPin});
      rd(`CCP_OFF_STAT, {31'h0, e[0]}, 32'h3);
      cmp32({31'h0, e[0] & e[3]}, {31'h0, irq});
      cmp32({31'h0, e[27:24] == 4'hB && !e[21]}, {31'h0, nT1 != t1});
      cmp32({31'h0, e[27:24] == 4'hB && e[21]}, {31'h0, nT3 != t3});
      wr(`CCP_OFF_CTRL1, 32'h0);
      wr(`CCP_OFF_STAT, 32'h3);
    end
    // off returns the pin to reset
    wr(`CCP_OFF_CTRL1, 32'h9);
    wr(`CCP_OFF_CTRL1, 32'h0);
    @(negedge clk) cmp32(32'h0, {30'h0, cmpPin});
    $display("test compare done");
    for (int m = 0; m < 4; m++) begin
      np = (m == 0) ? 1 : (m == 1) ? 2 : (m == 2) ? 5 : 17;
      dv = (m == 2) ? 4 : (m == 3) ? 16 : 1;
      wr(`CCP_OFF_CTRL1, 32'h4 + 32'(m));
      for (int k = 1; k <= np; k++) pulse(base + 16'(k));
      rd(`CCP_OFF_VAL1, {16'h0, m == 0 ? ~(base + 16'd1) : base + 16'(np - np % dv)});
      rd(`CCP_OFF_STAT, 32'h1, 32'h3);
      wr(`CCP_OFF_CTRL1, 32'h0);
      wr(`CCP_OFF_STAT, 32'h3);
    end
    $display("test capture done");
    // unit two compare on the third timer
    wr(`CCP_OFF_MASK, 32'h2);
    wr(`CCP_OFF_TSRC, 32'h1);
    wr(`CCP_OFF_VAL2, 32'h10);
    setT(16'h8000);
    wr(`CCP_OFF_CTRL2, 32'h8);
    @(negedge clk) cmp32(32'h0, {31'h0, cmpPin[1]});
    @(posedge clk) run <= 1'b1;
    repeat (40) @(posedge clk);
    run <= 1'b0;
    @(negedge clk) cmp32(32'h1, {31'h0, cmpPin[1]});
    cmp32(32'h1, {31'h0, irq});
    wr(`CCP_OFF_CTRL2, 32'h0);
    wr(`CCP_OFF_STAT, 32'h3);
    $display("test unit two done");
    // message capture on unit one only
    wr(`CCP_OFF_VAL2, {16'h0, base});
    wr(`CCP_OFF_CTRL1, 32'h3);
    wr(`CCP_OFF_CTRL2, 32'h3);
    setT(~base);
    msgReceived <= 1'b1;
    repeat (6) @(posedge clk);
    msgReceived <= 1'b0;
    rd(`CCP_OFF_VAL1, {16'h0, ~base});
    rd(`CCP_OFF_VAL2, {16'h0, base});
    wr(`CCP_OFF_CTRL2, 32'h0);
    $display("test message done");
    wr(`CCP_OFF_VAL1, 32'hABCD_0040);
    rd(`CCP_OFF_VAL1, 32'h40);
    wr(`CCP_OFF_CTRL1, 32'hDC);
    rd(`CCP_OFF_CTRL1, 32'h1C);
    repeat (4) @(posedge clk);
    cnt = 32'h0;
    repeat (1024) begin @(negedge clk); cnt += {31'h0, cmpPin[0]}; end
    cmp32(32'd257, cnt);
    $display("test pwm done");
    results();
  end
endmodule
